// ===== rtl/ifa_pkg.sv
// Purpose: constants for the two-wire filter, arbitration and address block
// Assumes: single 10 MHz clock, plain register port
// Notes: register indices are word indices on the plain port
package ifa_pkg;
	localparam int CLK_NS = 100;
	localparam int SPIKE_NS = 50;
	localparam int SPIKE_CYC = ((SPIKE_NS + CLK_NS - 1) / CLK_NS < 1) ? 1 :
		(SPIKE_NS + CLK_NS - 1) / CLK_NS;
	localparam int TOUT_MS = 25;
	localparam int TOUT_CYC = TOUT_MS * 1000000 / CLK_NS;
	localparam logic [4:0] FILT_MIN = 5'h03;
	localparam logic [4:0] FILT_MAX = 5'h15;
	localparam logic [4:0] FILT_RST = 5'h03;
	localparam logic [7:0] DIV_RST = 8'h31;
	localparam logic [6:0] OWN_RST = 7'h00;
	localparam logic [7:0] GC_ADDR = 8'h00;
	localparam logic [2:0] A_CTRL = 3'h0;
	localparam logic [2:0] A_DIV = 3'h1;
	localparam logic [2:0] A_FILT = 3'h2;
	localparam logic [2:0] A_OWN = 3'h3;
	localparam logic [2:0] A_TX = 3'h4;
	localparam logic [2:0] A_STAT = 3'h5;
	localparam int C_EN = 0;
	localparam int C_GO = 1;
	localparam int S_OWN = 0;
	localparam int S_GC = 1;
	localparam int S_ARB = 2;
	localparam int S_TOUT = 3;
	localparam int S_BUSY = 4;
	localparam int S_MACT = 5;
	localparam int S_DONE = 6;
	localparam logic [3:0] BITS_LAST = 4'h8;
	typedef enum logic [3:0] {
		M_IDLE = 4'h1,
		M_START = 4'h2,
		M_BITS = 4'h4,
		M_STOP = 4'h8
	} ifa_mstate_type;
endpackage

// ===== rtl/ifa_core.sv
// Purpose: two-wire bus front end: filter, arbitration, clock sync, time-out, address match
// Assumes: open-drain pins as in/out/oe triplets, oe high pulls the line low
// Notes: master sends one byte from the transmit register, then a stop
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module ifa_core #(
	parameter int low_timeout_cycles = ifa_pkg::TOUT_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe
);
	import ifa_pkg::*;

	function automatic logic [4:0] clamp_len(input logic [4:0] v);
		clamp_len = (v < FILT_MIN) ? FILT_MIN : ((v > FILT_MAX) ? FILT_MAX : v);
	endfunction

	logic enable;
	logic go;
	logic [7:0] serial_clock_divider_control;
	logic [4:0] filt_len;
	logic [6:0] own_addr;
	logic [7:0] tx_byte;
	logic st_own, st_gc, st_arb, st_tout, st_done;
	logic [1:0] pin_in;
	logic [1:0] sync_q1, sync_s, filt;
	logic [4:0] fcnt [1:0];
	logic scl_f, sda_f, scl_f_d, sda_f_d;
	logic bus_busy;
	ifa_mstate_type state;
	logic [7:0] cnt;
	logic hi_phase, hi_seen, sda_pend, stop_step;
	logic [3:0] bitn;
	logic [7:0] shreg;
	logic [19:0] tout_cnt;
	logic tout_hit, arb_lose, abort, tick, master_act;
	logic addr_phase, addr_done;
	logic [2:0] abit;
	logic [7:0] rx_shift, addr_byte;
	logic scl_rise, start_det, stop_det;
	logic w_stat;

	// =========================================================
	// Register port
	assign w_stat = reg_wr && reg_addr == A_STAT;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			enable <= 1'b0;
			serial_clock_divider_control <= DIV_RST;
			filt_len <= FILT_RST;
			own_addr <= OWN_RST;
			tx_byte <= 8'h00;
		end else if (reg_wr) begin
			case (reg_addr)
				A_CTRL: enable <= reg_wdata[C_EN];
				A_DIV: serial_clock_divider_control <= reg_wdata;
				A_FILT: filt_len <= reg_wdata[4:0];
				A_OWN: own_addr <= reg_wdata[6:0];
				A_TX: tx_byte <= reg_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			go <= 1'b0;
		else
			go <= reg_wr && reg_addr == A_CTRL && reg_wdata[C_GO] && reg_wdata[C_EN];
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				A_CTRL: reg_rdata <= {7'h00, enable};
				A_DIV: reg_rdata <= serial_clock_divider_control;
				A_FILT: reg_rdata <= {3'h0, filt_len};
				A_OWN: reg_rdata <= {1'b0, own_addr};
				A_TX: reg_rdata <= tx_byte;
				A_STAT: reg_rdata <= {1'b0, st_done, master_act, bus_busy,
					st_tout, st_arb, st_gc, st_own};
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// =========================================================
	// Synchronisers and glitch filters, index 0 clock, 1 data
	assign pin_in = {sda_in, scl_in};
	for (genvar i = 0; i < 2; i++) begin : g_line
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				sync_q1[i] <= 1'b1;
				sync_s[i] <= 1'b1;
			end else begin
				sync_q1[i] <= pin_in[i];
				sync_s[i] <= sync_q1[i];
			end
		end
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				filt[i] <= 1'b1;
				fcnt[i] <= 5'h00;
			end else if (sync_s[i] == filt[i]) begin
				fcnt[i] <= 5'h00;
			end else if (fcnt[i] + 5'h01 >= clamp_len(filt_len)) begin
				filt[i] <= sync_s[i];
				fcnt[i] <= 5'h00;
			end else begin
				fcnt[i] <= fcnt[i] + 5'h01;
			end
		end
	end
	assign scl_f = filt[0];
	assign sda_f = filt[1];

	// =========================================================
	// Bus condition detection
	assign scl_rise = scl_f && !scl_f_d;
	assign start_det = scl_f && scl_f_d && sda_f_d && !sda_f;
	assign stop_det = scl_f && scl_f_d && !sda_f_d && sda_f;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			scl_f_d <= 1'b1;
			sda_f_d <= 1'b1;
			bus_busy <= 1'b0;
		end else begin
			scl_f_d <= scl_f;
			sda_f_d <= sda_f;
			if (start_det)
				bus_busy <= 1'b1;
			else if (stop_det || tout_hit)
				bus_busy <= 1'b0;
		end
	end

	// =========================================================
	// Clock-low time-out
	assign tout_hit = bus_busy && !scl_f && tout_cnt == 20'(low_timeout_cycles - 1);
	always_ff @(posedge clk) begin
		if (sys_rst || scl_f || !bus_busy)
			tout_cnt <= 20'h00000;
		else if (!tout_hit)
			tout_cnt <= tout_cnt + 20'h00001;
	end

	// =========================================================
	// Master clock generator with arbitration
	assign master_act = state != M_IDLE;
	assign tick = cnt == serial_clock_divider_control;
	assign arb_lose = state == M_BITS && hi_phase && !sda_oe && scl_f && !sda_f
		&& bitn != BITS_LAST;
	assign abort = arb_lose || tout_hit || !enable;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= M_IDLE;
			cnt <= 8'h00;
			hi_phase <= 1'b0;
			hi_seen <= 1'b0;
			sda_pend <= 1'b0;
			stop_step <= 1'b0;
			bitn <= 4'h0;
			shreg <= 8'h00;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
		end else if (abort && master_act) begin
			state <= M_IDLE;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			cnt <= 8'h00;
		end else begin
			case (state)
				M_IDLE: begin
					scl_oe <= 1'b0;
					sda_oe <= 1'b0;
					cnt <= 8'h00;
					if (go && !bus_busy) begin
						sda_oe <= 1'b1;
						shreg <= tx_byte;
						state <= M_START;
					end
				end
				M_START: begin
					cnt <= tick ? 8'h00 : cnt + 8'h01;
					if (tick) begin
						scl_oe <= 1'b1;
						hi_phase <= 1'b0;
						sda_pend <= 1'b1;
						bitn <= 4'h0;
						state <= M_BITS;
					end
				end
				M_BITS: begin
					if (sda_pend) begin
						sda_pend <= 1'b0;
						sda_oe <= (bitn == BITS_LAST) ? 1'b0 : !shreg[7];
					end
					if (!hi_phase) begin
						cnt <= tick ? 8'h00 : cnt + 8'h01;
						if (tick) begin
							scl_oe <= 1'b0;
							hi_phase <= 1'b1;
							hi_seen <= 1'b0;
						end
					end else begin
						if (scl_f)
							hi_seen <= 1'b1;
						// High time counts only once the line is really high
						if (scl_f)
							cnt <= tick ? 8'h00 : cnt + 8'h01;
						if ((scl_f && tick) || (hi_seen && !scl_f)) begin
							scl_oe <= 1'b1;
							cnt <= 8'h00;
							hi_phase <= 1'b0;
							if (bitn == BITS_LAST) begin
								state <= M_STOP;
								stop_step <= 1'b0;
							end else begin
								bitn <= bitn + 4'h1;
								shreg <= {shreg[6:0], 1'b0};
								sda_pend <= 1'b1;
							end
						end
					end
				end
				M_STOP: begin
					cnt <= tick ? 8'h00 : cnt + 8'h01;
					if (!stop_step && !sda_pend) begin
						sda_oe <= 1'b1;
						sda_pend <= 1'b1;
					end else if (tick) begin
						if (!stop_step) begin
							scl_oe <= 1'b0;
							stop_step <= 1'b1;
						end else begin
							sda_oe <= 1'b0;
							sda_pend <= 1'b0;
							state <= M_IDLE;
						end
					end
				end
				default: state <= M_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end
	end

	// =========================================================
	// Address receiver
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			addr_phase <= 1'b0;
			addr_done <= 1'b0;
			abit <= 3'h0;
			rx_shift <= 8'h00;
			addr_byte <= 8'h00;
		end else begin
			addr_done <= 1'b0;
			if (start_det) begin
				addr_phase <= 1'b1;
				abit <= 3'h0;
			end else if (stop_det) begin
				addr_phase <= 1'b0;
			end else if (addr_phase && scl_rise) begin
				rx_shift <= {rx_shift[6:0], sda_f};
				abit <= abit + 3'h1;
				if (abit == 3'h7) begin
					addr_phase <= 1'b0;
					addr_done <= 1'b1;
					addr_byte <= {rx_shift[6:0], sda_f};
				end
			end
		end
	end

	// =========================================================
	// Sticky status, set wins over write-one-to-clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_own <= 1'b0;
			st_gc <= 1'b0;
			st_arb <= 1'b0;
			st_tout <= 1'b0;
			st_done <= 1'b0;
		end else begin
			if (addr_done && !master_act && addr_byte[7:1] == own_addr)
				st_own <= 1'b1;
			else if (w_stat && reg_wdata[S_OWN])
				st_own <= 1'b0;
			if (addr_done && !master_act && addr_byte[7:1] != own_addr
				&& addr_byte == GC_ADDR)
				st_gc <= 1'b1;
			else if (w_stat && reg_wdata[S_GC])
				st_gc <= 1'b0;
			if (arb_lose)
				st_arb <= 1'b1;
			else if (w_stat && reg_wdata[S_ARB])
				st_arb <= 1'b0;
			if (tout_hit)
				st_tout <= 1'b1;
			else if (w_stat && reg_wdata[S_TOUT])
				st_tout <= 1'b0;
			if (state == M_STOP && stop_step && tick)
				st_done <= 1'b1;
			else if (w_stat && reg_wdata[S_DONE])
				st_done <= 1'b0;
		end
	end

	// =========================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	filt_min_len_a: assert property ($rose(scl_f) |-> $past(sync_s[0], 1) && $past(sync_s[0], 2)
		&& $past(sync_s[0], 3)) else $error("clock filter passed short pulse");
	spike_rej_a: assert property ($fell(sda_f) |-> !$past(sync_s[1], 2) && !$past(sync_s[1], 3))
		else $error("data filter passed spike");
	sync_path_a: assert property ($rose(sync_s[1]) |-> $past(sda_in, 2))
		else $error("data synchroniser path broken");
	arb_leave_a: assert property (arb_lose |=> state == M_IDLE && st_arb)
		else $error("master kept after data conflict");
	arb_release_a: assert property (arb_lose |=> !sda_oe && !scl_oe ##1 !scl_oe)
		else $error("lines still driven after loss");
	clk_wait_a: assert property (state == M_BITS && hi_phase && !scl_oe && !scl_f && !hi_seen
		&& !abort |=> !scl_oe) else $error("clock low pulled early while stretched");
	tout_flag_a: assert property (tout_hit |=> st_tout && !bus_busy && !master_act)
		else $error("time-out not reported");
	own_match_a: assert property (addr_done && !master_act && addr_byte[7:1] == own_addr
		|=> st_own) else $error("own address match lost");
	gc_match_a: assert property (addr_done && !master_act && addr_byte[7:1] != own_addr
		&& addr_byte == 8'h00 |=> st_gc) else $error("general call not flagged");
	no_false_match_a: assert property (!addr_done && !(w_stat && reg_wdata[S_OWN])
		|=> st_own == $past(st_own)) else $error("status changed without match");
	slave_idle_a: assert property (state == M_IDLE && $past(state) == M_IDLE |-> !scl_oe)
		else $error("clock driven outside master mode");
	div_hold_a: assert property (state == M_START && !tick && !abort |=> state == M_START)
		else $error("start left before divider count");

	own_cov_c: cover property (addr_done ##1 st_own);
	gc_cov_c: cover property (addr_done ##1 st_gc);
	arb_cov_c: cover property (state == M_BITS ##1 arb_lose);
	done_cov_c: cover property (state == M_STOP ##1 state == M_IDLE);
endmodule // ifa_core

// ===== tb/ifa_bus_partner.sv
// Purpose: far side of the two-wire bus: pull-ups, a second master or slave
// Assumes: open-drain lines, a pull enable high pulls the line low
// Notes: driven by task calls from the bench
`timescale 1ns/100ps
module ifa_bus_partner #(
	parameter int half_cycles = 40
) (
	input wire logic clk,
	input wire logic dut_scl_oe,
	input wire logic dut_sda_oe,
	output logic scl,
	output logic sda
);
	logic p_scl = 1'b0;
	logic p_sda = 1'b0;
	// =========================================
	// Wired-AND lines with pull-ups
	assign scl = !(dut_scl_oe || p_scl);
	assign sda = !(dut_sda_oe || p_sda);
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic start_cond();
		p_sda <= 1'b1;
		wait_cyc(half_cycles);
		p_scl <= 1'b1;
		wait_cyc(half_cycles);
	endtask
	task automatic stop_cond();
		p_sda <= 1'b1;
		wait_cyc(half_cycles);
		p_scl <= 1'b0;
		wait_cyc(half_cycles);
		p_sda <= 1'b0;
		wait_cyc(half_cycles);
	endtask
	task automatic glitch(input int n);
		p_sda <= 1'b1;
		wait_cyc(n);
		p_sda <= 1'b0;
		wait_cyc(half_cycles);
	endtask
	// Eight data bits MSB first, ninth clock with data released
	task automatic send_byte(input logic [7:0] b);
		for (int i = 0; i < 9; i++) begin
			p_sda <= (i < 8) ? !b[7 - i] : 1'b0;
			wait_cyc(half_cycles);
			p_scl <= 1'b0;
			wait_cyc(half_cycles);
			p_scl <= 1'b1;
		end
		wait_cyc(half_cycles);
	endtask
	// Samples on clock rise; stretches the low phase after bit 3
	task automatic capture(output logic [7:0] b);
		b = 8'h00;
		for (int i = 0; i < 8; i++) begin
			while (scl) @(posedge clk);
			while (!scl) @(posedge clk);
			b = {b[6:0], sda};
			if (i == 3) begin
				while (scl) @(posedge clk);
				p_scl <= 1'b1;
				wait_cyc(50);
				p_scl <= 1'b0;
			end
		end
	endtask
endmodule // ifa_bus_partner

// ===== tb/i2c_filter_arbitration_addr_bench.sv
// Purpose: self-checking bench for the two-wire front end
// Assumes: partner model on the bus, short time-out parameter
// Notes: status bits: 0 own, 1 general call, 2 lost, 3 time-out, 4 busy, 6 done
`timescale 1ns/100ps
module i2c_filter_arbitration_addr_bench;
	import ifa_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic scl_out, scl_oe, sda_out, sda_oe, scl, sda;
	logic [7:0] b;
	int miscompares = 0;
	int tests_run = 0;
	always #50 clk = ~clk;
	ifa_core #(.low_timeout_cycles(200)) i_dut (.clk(clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
	ifa_bus_partner #(.half_cycles(40)) i_partner (.clk(clk), .dut_scl_oe(scl_oe),
		.dut_sda_oe(sda_oe), .scl(scl), .sda(sda));
	// =========================================
	// Register port and compares
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic check_reg(input logic [2:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd_reg(a, d);
		check8(d, exp);
	endtask
	task automatic finish_test();
		$display("miscompares %0d tests_run %0d", miscompares, tests_run);
		if (miscompares == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// =========================================
	// Scenarios
	task automatic t_regs();
		check_reg(A_DIV, DIV_RST);
		check_reg(A_FILT, FILT_RST);
		check_reg(A_OWN, OWN_RST);
		check_reg(A_STAT, 8'h00);
		check_reg(3'h6, 8'h00);
		// Length is stored as written and clamped where the filter uses it
		wr_reg(A_FILT, 8'h1F);
		check_reg(A_FILT, 8'h1F);
		wr_reg(A_FILT, 8'h00);
		check_reg(A_FILT, 8'h00);
		// Half period must outlast the filter delay, or the master swallows its own clock
		wr_reg(A_DIV, 8'h13);
		check_reg(A_DIV, 8'h13);
	endtask
	task automatic t_glitch();
		wr_reg(A_FILT, 8'h05);
		i_partner.glitch(3);
		check_reg(A_STAT, 8'h00);
		i_partner.start_cond();
		check_reg(A_STAT, 8'h10);
		i_partner.stop_cond();
		check_reg(A_STAT, 8'h00);
	endtask
	task automatic t_addr(input logic [7:0] a, input logic [7:0] exp);
		i_partner.start_cond();
		i_partner.send_byte(a);
		check_reg(A_STAT, exp);
		check8({7'h00, scl_oe}, 8'h00);
		i_partner.stop_cond();
		wr_reg(A_STAT, 8'h4F);
	endtask
	task automatic t_master();
		wr_reg(A_TX, 8'hA5);
		wr_reg(A_CTRL, 8'h03);
		i_partner.capture(b);
		check8(b, 8'hA5);
		check8({6'h00, sda_out, scl_out}, 8'h00);
		b = 8'h00;
		for (int i = 0; i < 200 && !b[6]; i++)
			rd_reg(A_STAT, b);
		// Let the filtered stop clear busy before the final read
		repeat (20) @(posedge clk);
		check_reg(A_STAT, 8'h40);
		wr_reg(A_STAT, 8'h4F);
	endtask
	task automatic t_arb();
		wr_reg(A_TX, 8'hFF);
		wr_reg(A_CTRL, 8'h03);
		while (scl) @(posedge clk);
		i_partner.p_sda <= 1'b1;
		repeat (40) @(posedge clk);
		check8({6'h00, sda_oe, scl_oe}, 8'h00);
		check_reg(A_STAT, 8'h14);
		i_partner.p_sda <= 1'b0;
		repeat (40) @(posedge clk);
		wr_reg(A_STAT, 8'h4F);
	endtask
	task automatic t_tout();
		i_partner.start_cond();
		repeat (300) @(posedge clk);
		check_reg(A_STAT, 8'h08);
		i_partner.p_scl <= 1'b0;
		repeat (40) @(posedge clk);
		i_partner.p_sda <= 1'b0;
		repeat (40) @(posedge clk);
		wr_reg(A_STAT, 8'h4F);
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		finish_test();
	end
	initial begin
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		t_regs();
		t_glitch();
		wr_reg(A_OWN, 8'h5A);
		t_addr(8'hB4, 8'h11);
		t_addr(GC_ADDR, 8'h12);
		t_addr(8'h36, 8'h10);
		t_master();
		t_arb();
		t_tout();
		finish_test();
	end
endmodule // i2c_filter_arbitration_addr_bench
